// file: rtl/lfis_slave.sv
// What this block does
// - slave with four eight-bit registers
// - decode seven-bit addresses only
// - works at 100 and 400 kbit/s
// - slave address 0110111, bytes 6E/6F
// - write: address, index, data, stop
// - one index and one data byte
// - combined read returns indexed byte
// - index kept across stop and traffic
// - index never auto-increments
// - start, stop and repeated start framing
// - control index 2: current, timeout, reserved
// - timeout switches flash off after 1s
// - rearm by enable low or code rewrite
`timescale 1ns/1ps
`default_nettype none
module lfis_slave
  import lfis_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = LFIS_TIMEOUT_CYCLES
) (
  input wire logic sys_clk, // system clock
  input wire logic reset, // async reset, high
  input wire logic sclIn, // bus clock pin
  input wire logic sdaIn, // bus data pin level
  output logic sdaOut, // data pin drive value, always low
  output logic sdaOe, // data pin driven low while high
  input wire logic flash_enable_pin, // external flash trigger
  output logic [7:0] led_sink_current, // active current code
  output logic ledOn, // current sink enabled
  output logic flash_timeout_enable, // timeout bit of control
  output logic timedOut // safety timeout latched
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_INDEX = 6'b000100,
    ST_DATA = 6'b001000,
    ST_READ = 6'b010000,
    ST_IGNORE = 6'b100000
  } lfis_state_type;

  typedef struct packed {
    lfis_state_type fsm;
    logic [7:0] shift;
    logic [3:0] bitCount;
    logic ackPhase;
    logic drive;
    logic [1:0] index;
    logic [LFIS_REG_COUNT-1:0][7:0] regs;
    logic [1:0] enPin;
    logic enPrev;
    logic rearm;
  } lfis_slave_type;

  lfis_slave_type state_r;
  lfis_slave_type state_nxt;
  lfis_bus_event_type busEvent;
  logic expired;
  logic [7:0] ctrl;
  logic armed;

  lfis_bus_sampler u_sampler (
    .sys_clk(sys_clk),
    .reset(reset),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .busEvent(busEvent)
  );

  assign ctrl = state_r.regs[LFIS_CTRL_INDEX[1:0]];
  assign armed = (ctrl & LFIS_CODE_MASK) != 8'h00;

  lfis_flash_timer #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(armed && ctrl[LFIS_TIMEOUT_BIT] && state_r.enPin[1]),
    .rearm(state_r.rearm),
    .expired(expired)
  );

  always_comb begin
    state_nxt = state_r;
    state_nxt.rearm = 1'b0;
    state_nxt.enPin = {state_r.enPin[0], flash_enable_pin};
    state_nxt.enPrev = state_r.enPin[1];
    if (state_r.enPrev && !state_r.enPin[1]) begin
      state_nxt.rearm = 1'b1;
    end
    if (busEvent.stopSeen) begin
      state_nxt.fsm = ST_IDLE;
      state_nxt.drive = 1'b0;
    end else if (busEvent.startSeen) begin
      // repeated start also lands here; index survives it
      state_nxt.fsm = ST_ADDR;
      state_nxt.bitCount = 4'h0;
      state_nxt.ackPhase = 1'b0;
      state_nxt.drive = 1'b0;
    end else if (busEvent.sclRise) begin
      if (!state_r.ackPhase && state_r.fsm != ST_READ &&
          state_r.fsm != ST_IDLE && state_r.fsm != ST_IGNORE) begin
        state_nxt.shift = {state_r.shift[6:0], busEvent.sdaLevel};
        state_nxt.bitCount = state_r.bitCount + 4'h1;
      end else if (state_r.ackPhase && state_r.fsm == ST_READ) begin
        // master nack ends the read; an ack gets the indexed byte again
        if (busEvent.sdaLevel) begin
          state_nxt.fsm = ST_IGNORE;
        end
      end
    end else if (busEvent.sclFall) begin
      if (state_r.ackPhase) begin
        state_nxt.ackPhase = 1'b0;
        state_nxt.drive = 1'b0;
        state_nxt.bitCount = 4'h0;
        if (state_r.fsm == ST_READ) begin
          state_nxt.shift = state_r.regs[state_r.index];
          state_nxt.drive = ~state_nxt.shift[7];
          state_nxt.ackPhase = 1'b0;
          state_nxt.bitCount = 4'h1;
        end
      end else if (state_r.fsm == ST_READ) begin
        if (state_r.bitCount == 4'h8) begin
          state_nxt.drive = 1'b0;
          state_nxt.ackPhase = 1'b1;
        end else begin
          state_nxt.shift = {state_r.shift[6:0], 1'b0};
          state_nxt.drive = ~state_r.shift[6];
          state_nxt.bitCount = state_r.bitCount + 4'h1;
        end
      end else if (state_r.bitCount == 4'h8) begin
        case (state_r.fsm)
          ST_ADDR: begin
            if (state_r.shift[7:1] == LFIS_SLAVE_ADDR) begin
              state_nxt.drive = 1'b1;
              state_nxt.ackPhase = 1'b1;
              state_nxt.fsm = state_r.shift[0] ? ST_READ : ST_INDEX;
            end else begin
              state_nxt.fsm = ST_IGNORE;
            end
          end
          ST_INDEX: begin
            state_nxt.index = state_r.shift[1:0];
            state_nxt.drive = 1'b1;
            state_nxt.ackPhase = 1'b1;
            state_nxt.fsm = ST_DATA;
          end
          ST_DATA: begin
            state_nxt.regs[state_r.index] = state_r.shift;
            state_nxt.drive = 1'b1;
            state_nxt.ackPhase = 1'b1;
            // further bytes get no ack until a new start
            state_nxt.fsm = ST_IGNORE;
            if (state_r.index == LFIS_CTRL_INDEX[1:0]) begin
              state_nxt.rearm = 1'b1;
            end
          end
          default: begin
            state_nxt.fsm = ST_IGNORE;
          end
        endcase
      end
    end else if (state_r.ackPhase && state_r.fsm == ST_IGNORE &&
                 !busEvent.sclRise) begin
      state_nxt.drive = state_r.drive;
    end
    // ack after the data byte must still be released on the next fall
    if (busEvent.sclFall && state_r.ackPhase && state_r.fsm == ST_IGNORE) begin
      state_nxt.drive = 1'b0;
      state_nxt.ackPhase = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r.fsm <= ST_IDLE;
      state_r.shift <= 8'h00;
      state_r.bitCount <= 4'h0;
      state_r.ackPhase <= 1'b0;
      state_r.drive <= 1'b0;
      state_r.index <= 2'h0;
      state_r.regs <= {LFIS_REG_RESET, LFIS_CTRL_RESET, LFIS_REG_RESET,
                       LFIS_REG_RESET};
      state_r.enPin <= 2'h0;
      state_r.enPrev <= 1'b0;
      state_r.rearm <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // the sampler delay of a few system cycles is far below a fast-mode
  // hold time, so data changes still land inside the clock low phase
  assign sdaOut = 1'b0;
  assign sdaOe = state_r.drive;
  assign led_sink_current = ctrl & LFIS_CODE_MASK;
  assign ledOn = armed && state_r.enPin[1] && !expired;
  assign flash_timeout_enable = ctrl[LFIS_TIMEOUT_BIT];
  assign timedOut = expired;
endmodule // lfis_slave
`default_nettype wire

// file: rtl/lfis_pkg.sv
package lfis_pkg;
  localparam logic [6:0] LFIS_SLAVE_ADDR = 7'h37;
  localparam int LFIS_REG_COUNT = 4;
  localparam logic [7:0] LFIS_CTRL_INDEX = 8'h02;
  localparam logic [7:0] LFIS_CTRL_RESET = 8'h10;
  localparam logic [7:0] LFIS_REG_RESET = 8'h00;
  localparam int LFIS_TIMEOUT_BIT = 4;
  localparam int LFIS_RESERVED_BIT = 5;
  localparam logic [7:0] LFIS_CODE_MASK = 8'hcf;
  localparam int LFIS_CLK_HZ = 125000000;
  localparam int LFIS_TIMEOUT_MS = 1000;
  localparam int LFIS_TIMEOUT_CYCLES = LFIS_CLK_HZ / 1000 * LFIS_TIMEOUT_MS;

  typedef struct packed {
    logic startSeen;
    logic stopSeen;
    logic sclRise;
    logic sclFall;
    logic sdaLevel;
  } lfis_bus_event_type;

  typedef struct packed {
    logic valid;
    logic [1:0] index;
    logic [7:0] data;
  } lfis_write_type;
endpackage

// file: rtl/lfis_bus_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module lfis_bus_sampler
  import lfis_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic reset, // async reset, high
  input wire logic sclIn, // bus clock pin
  input wire logic sdaIn, // bus data pin
  output lfis_bus_event_type busEvent // decoded bus events
);
  typedef struct packed {
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic sclOld;
    logic sdaOld;
  } lfis_sampler_type;

  lfis_sampler_type state_r;
  lfis_sampler_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    state_nxt.sclSync = {state_r.sclSync[0], sclIn};
    state_nxt.sdaSync = {state_r.sdaSync[0], sdaIn};
    state_nxt.sclOld = state_r.sclSync[1];
    state_nxt.sdaOld = state_r.sdaSync[1];
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= '{sclSync: 2'h3, sdaSync: 2'h3, sclOld: 1'b1, sdaOld: 1'b1};
    end else begin
      state_r <= state_nxt;
    end
  end

  // start and stop are data edges while the clock stays high
  assign busEvent.startSeen = state_r.sclSync[1] & state_r.sclOld &
                              state_r.sdaOld & ~state_r.sdaSync[1];
  assign busEvent.stopSeen = state_r.sclSync[1] & state_r.sclOld &
                             ~state_r.sdaOld & state_r.sdaSync[1];
  assign busEvent.sclRise = state_r.sclSync[1] & ~state_r.sclOld;
  assign busEvent.sclFall = ~state_r.sclSync[1] & state_r.sclOld;
  assign busEvent.sdaLevel = state_r.sdaSync[1];
endmodule // lfis_bus_sampler
`default_nettype wire

// file: rtl/lfis_flash_timer.sv
`timescale 1ns/1ps
`default_nettype none
module lfis_flash_timer
  import lfis_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = LFIS_TIMEOUT_CYCLES
) (
  input wire logic sys_clk, // system clock
  input wire logic reset, // async reset, high
  input wire logic run, // led requested on with timeout armed
  input wire logic rearm, // clear the expired latch
  output logic expired // safety timeout reached
);
  typedef struct packed {
    logic [27:0] count;
    logic expired;
  } lfis_timer_type;

  lfis_timer_type state_r;
  lfis_timer_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (rearm) begin
      state_nxt.count = 28'h0;
      state_nxt.expired = 1'b0;
    end else if (run && !state_r.expired) begin
      if (state_r.count == 28'(TIMEOUT_CYCLES - 1)) begin
        state_nxt.expired = 1'b1;
      end else begin
        state_nxt.count = state_r.count + 28'h1;
      end
    end else if (!run) begin
      state_nxt.count = 28'h0;
    end
    // an expiry landing in the same cycle as a rearm still latches
    if (run && !state_r.expired &&
        state_r.count == 28'(TIMEOUT_CYCLES - 1)) begin
      state_nxt.expired = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= '{count: 28'h0, expired: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign expired = state_r.expired;
endmodule // lfis_flash_timer
`default_nettype wire

// file: verif/lfis_slave_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lfis_slave_properties
  import lfis_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = LFIS_TIMEOUT_CYCLES
) (
  input wire logic sys_clk, // clock
  input wire logic reset, // reset
  input wire logic sclIn, // bus clock
  input wire logic sdaIn, // bus data
  input wire logic sdaOut, // drive value
  input wire logic sdaOe, // pull enable
  input wire logic flash_enable_pin, // trigger
  input wire logic [7:0] led_sink_current, // code
  input wire logic ledOn, // sink on
  input wire logic flash_timeout_enable, // timeout bit
  input wire logic timedOut // timeout latch
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  int runCnt_r;
  // eight cycles of slack cover the pin synchronisers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) runCnt_r <= 0;
    else runCnt_r <= (ledOn && flash_timeout_enable) ? runCnt_r + 1 : 0;
  end
  a_drive_low: assert property (sdaOut == 1'b0)
    else $error("drive value not low");
  a_code_mask: assert property (led_sink_current[5:4] == 2'b00)
    else $error("masked bits set");
  a_led_gate: assert property ((timedOut || led_sink_current == 8'h00) [*2]
    |-> !ledOn)
    else $error("sink on while off");
  a_timeout_src: assert property ($rose(timedOut) |->
    $past(flash_timeout_enable))
    else $error("timeout without enable");
  a_pin_rearm: assert property (timedOut && $fell(flash_enable_pin)
    |-> ##[1:6] !timedOut)
    else $error("pin low did not rearm");
  a_timer_bound: assert property (runCnt_r <= TIMEOUT_CYCLES + 8)
    else $error("flash ran past timeout");
  a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data moved with clock high");
  a_oe_hold: assert property (sdaOe && $rose(sclIn) |-> sdaOe [*5])
    else $error("data dropped with clock high");
  cover property ($rose(timedOut));
  cover property ($rose(sdaOe));
  cover property ($rose(ledOn));
endmodule // lfis_slave_properties
`default_nettype wire

// file: verif/lfis_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module lfis_bus_master (
  output logic scl, // bus clock, high when idle
  output logic sdaLow, // pulls data low
  input wire logic sda // resolved data line
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // data moves 10 ns after the low edge so no false start or stop
  task automatic bitx(input logic tx, output logic rx);
    #10 sdaLow = ~tx;
    #30 scl = 1'b1;
    #20 rx = sda;
    #20 scl = 1'b0;
  endtask
  task automatic start;
    #10 sdaLow = 1'b0;
    #30 scl = 1'b1;
    #40 sdaLow = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic stop;
    #10 sdaLow = 1'b1;
    #30 scl = 1'b1;
    #40 sdaLow = 1'b0;
    #40;
  endtask
  // ninth bit released: device acks, or master nacks a read
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx,
    output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(1'b1, a);
    ack = ~a;
  endtask
endmodule // lfis_bus_master
`default_nettype wire

// file: verif/lfis_slave_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lfis_slave_tb_top;
  import lfis_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic flash_enable_pin = 1'b0;
  logic scl, sdaLow, sdaOut, sdaOe, ledOn, flash_timeout_enable, timedOut;
  logic [7:0] led_sink_current, rx;
  logic [7:0] vals [4] = '{8'h3c, 8'ha5, 8'h42, 8'h81};
  logic [7:0] bad [3] = '{8'h50, 8'hf0, 8'h6c};
  logic [7:0] spot [16] = '{8'h00, 8'h42, 8'hc2, 8'h02, 8'h46, 8'h04,
    8'hc6, 8'h4a, 8'h06, 8'h4e, 8'hca, 8'h08, 8'h45, 8'h47, 8'hce, 8'h49};
  int bad_count = 0;
  int checks = 0;
  wire logic sda = ~(sdaLow | (sdaOe & ~sdaOut)); // pulled up
  always #4 sys_clk = ~sys_clk;
  lfis_slave #(.TIMEOUT_CYCLES(200)) DUT (.sys_clk, .reset, .sclIn(scl),
    .sdaIn(sda), .sdaOut, .sdaOe, .flash_enable_pin, .led_sink_current,
    .ledOn, .flash_timeout_enable, .timedOut);
  lfis_bus_master mst (.scl, .sdaLow, .sda);
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic put(input logic [7:0] tx, input logic ackExp);
    logic a;
    mst.xbyte(tx, rx, a);
    check(a, ackExp);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    mst.start;
    put(8'h6e, 1'b1);
    put(idx, 1'b1);
    put(d, 1'b1);
    mst.stop;
  endtask
  task automatic readBack(input logic [7:0] exp);
    put(8'h6f, 1'b1);
    put(8'hff, 1'b0);
    check(rx, exp);
    mst.stop;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    mst.start;
    put(8'h6e, 1'b1);
    put(idx, 1'b1);
    mst.start;
    readBack(exp);
  endtask
  task automatic waitTo(input logic want);
    for (int n = 0; n < 400; n++) begin
      if (timedOut === want) return;
      @(posedge sys_clk) #1;
    end
    check(timedOut, want);
    conclude;
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    check(1'b0, 1'b1);
    conclude;
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 check(led_sink_current, 8'h00);
    check(flash_timeout_enable, 1'b1);
    rd(8'h02, LFIS_CTRL_RESET);
    for (int i = 0; i < 4; i++) wr(8'(i), vals[i]);
    for (int i = 3; i >= 0; i--) rd(8'(i), vals[i]);
    mst.start;
    put(8'h6e, 1'b1);
    put(8'h01, 1'b1);
    mst.stop;
    // foreign and ten-bit traffic must not disturb the held index
    foreach (bad[k]) begin
      mst.start;
      put(bad[k], 1'b0);
      put(8'h6f, 1'b0);
      mst.stop;
    end
    mst.start;
    readBack(vals[1]);
    mst.start;
    readBack(vals[1]);
    mst.start;
    put(8'h6e, 1'b1);
    put(8'h00, 1'b1);
    put(8'h77, 1'b1);
    put(8'h99, 1'b0);
    mst.stop;
    rd(8'h00, 8'h77);
    rd(8'h01, vals[1]);
    @(posedge sys_clk) #1 flash_enable_pin = 1'b1;
    foreach (spot[k]) begin
      wr(8'h02, spot[k]);
      repeat (8) @(posedge sys_clk);
      #1 check(led_sink_current, spot[k]);
      check({timedOut, flash_timeout_enable}, 2'b00);
      check(ledOn, spot[k] != 8'h00);
    end
    wr(8'h02, 8'h5b);
    #1 check(led_sink_current, 8'h4b);
    check({ledOn, flash_timeout_enable}, 2'b11);
    waitTo(1'b1);
    check(ledOn, 1'b0);
    @(posedge sys_clk) #1 flash_enable_pin = 1'b0;
    waitTo(1'b0);
    @(posedge sys_clk) #1 flash_enable_pin = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 check(ledOn, 1'b1);
    waitTo(1'b1);
    wr(8'h02, 8'h00);
    #1 check(timedOut, 1'b0);
    conclude;
  end
endmodule // lfis_slave_tb_top
bind lfis_slave lfis_slave_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
  props (.sys_clk, .reset, .sclIn, .sdaIn, .sdaOut, .sdaOe, .flash_enable_pin,
  .led_sink_current, .ledOn, .flash_timeout_enable, .timedOut);
`default_nettype wire
